/* File: rtl/timer8_waveform_control.sv */
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "timer8_map.svh"
module timer8_waveform_control (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    // Low-frequency source, sampled as an enable
    input wire logic I_LF_TICK,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    // Waveform pins
    output logic O_WAVE_OUT_A,
    output logic O_WAVE_OUT_B,
    output logic O_PIN_OVERRIDE_A,
    output logic O_PIN_OVERRIDE_B,
    // Events
    output logic O_MATCH_FLAG_A,
    output logic O_MATCH_FLAG_B,
    output logic O_OVERFLOW_FLAG
);
    typedef struct packed {
        timer8_pkg::ctrl_s ctrl;
        timer8_pkg::cmp_s cmp;
        timer8_pkg::cmp_s cmp_buf;
        timer8_pkg::flags_s flags;
        logic [7:0] counter_value;
        logic count_down;
        logic block_match;
        logic async_clock_sel;
        logic wave_out_a;
        logic wave_out_b;
        logic ovr_a;
        logic ovr_b;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } state_s;

    state_s cur;
    state_s nxt;
    logic presc_tick;
    logic src_en;

    // the low-frequency source acts as a clock enable, avoiding a second domain
    assign src_en = I_CE && (cur.async_clock_sel ? I_LF_TICK : 1'b1);

    timer8_prescaler u_prescaler (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_ce(src_en),
        .i_sel(cur.ctrl.clock_prescale_sel),
        .o_tick(presc_tick)
    );

    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == `MODE_PC_FF) || (m == `MODE_FAST_FF) || (m == `MODE_PC_OCRA) || (m == `MODE_FAST_OCRA);
    endfunction

    function automatic logic is_fast(input logic [2:0] m);
        is_fast = (m == `MODE_FAST_FF) || (m == `MODE_FAST_OCRA);
    endfunction

    // Output after a match event for the given action in the current mode
    function automatic logic match_out(input logic [1:0] act, input logic cur_v, input logic [2:0] m,
                                       input logic down);
        match_out = cur_v;
        if (!is_pwm(m)) begin
            case (act)
                `ACT_TOGGLE: match_out = ~cur_v;
                `ACT_CLEAR: match_out = 1'b0;
                `ACT_SET: match_out = 1'b1;
                default: match_out = cur_v;
            endcase
        end else if (act[1]) begin
            if (is_fast(m)) begin
                match_out = act[0];
            end else begin
                match_out = act[0] ^ down;
            end
        end
    endfunction

    logic [7:0] top;
    logic [2:0] mode;
    logic apb_wr;
    logic apb_rd;
    logic at_top;
    logic at_bottom;
    logic m_a;
    logic m_b;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic hit;
    // Overflow event of this tick, kept apart so that a software clear cannot swallow it
    logic ovf_ev;

    always_comb begin
        nxt = cur;
        mode = cur.ctrl.wave_mode_sel;
        top = (mode == `MODE_CTC || mode == `MODE_PC_OCRA || mode == `MODE_FAST_OCRA) ?
              cur.cmp.compare_value_a : `COUNT_MAX;
        at_top = (cur.counter_value == top);
        at_bottom = (cur.counter_value == `COUNT_BOTTOM);
        apb_wr = I_PSEL && I_PENABLE && I_PWRITE && !cur.pready;
        apb_rd = I_PSEL && I_PENABLE && !I_PWRITE && !cur.pready;
        wdat = I_PWDATA[7:0];
        m_a = 1'b0;
        m_b = 1'b0;
        rdat = 8'h00;
        hit = 1'b1;
        ovf_ev = 1'b0;

        // Counting, gated by the selected count tick
        if (presc_tick) begin
            // compare against the counter; blocked for one tick after a counter write
            m_a = !cur.block_match && (cur.counter_value == cur.cmp.compare_value_a);
            m_b = !cur.block_match && (cur.counter_value == cur.cmp.compare_value_b);
            nxt.block_match = 1'b0;
            if (is_pwm(mode) && !is_fast(mode)) begin
                if (!cur.count_down) begin
                    if (at_top) begin
                        nxt.count_down = 1'b1;
                        nxt.counter_value = cur.counter_value - 8'h01;
                        nxt.cmp = cur.cmp_buf;
                    end else begin
                        nxt.counter_value = cur.counter_value + 8'h01;
                    end
                end else if (at_bottom) begin
                    nxt.count_down = 1'b0;
                    nxt.counter_value = cur.counter_value + 8'h01;
                    nxt.flags.overflow = 1'b1;
                    ovf_ev = 1'b1;
                end else begin
                    nxt.counter_value = cur.counter_value - 8'h01;
                end
                // compare equal to TOP with upper bit set acts at TOP
                if (m_b && !(cur.ctrl.out_b_action[1] && cur.cmp.compare_value_b == top)) begin
                    nxt.wave_out_b = match_out(cur.ctrl.out_b_action, cur.wave_out_b, mode, cur.count_down);
                end else if (at_top && cur.ctrl.out_b_action[1] && cur.cmp.compare_value_b == top) begin
                    nxt.wave_out_b = match_out(cur.ctrl.out_b_action, cur.wave_out_b, mode, 1'b0);
                end
                if (m_a) begin
                    nxt.wave_out_a = match_out(cur.ctrl.out_a_action, cur.wave_out_a, mode, cur.count_down);
                end
            end else begin
                if (at_top && mode != `MODE_NORMAL) begin
                    nxt.counter_value = `COUNT_BOTTOM;
                end else begin
                    nxt.counter_value = cur.counter_value + 8'h01;
                end
                if ((mode == `MODE_FAST_OCRA) ? at_top : (cur.counter_value == `COUNT_MAX)) begin
                    nxt.flags.overflow = 1'b1;
                    ovf_ev = 1'b1;
                end
                if (is_fast(mode)) begin
                    // buffered compares load as the counter returns to BOTTOM
                    if (at_top) begin
                        nxt.cmp = cur.cmp_buf;
                        // set or clear at bottom regardless of ignored TOP match
                        if (cur.ctrl.out_a_action[1]) begin
                            nxt.wave_out_a = ~cur.ctrl.out_a_action[0];
                        end
                        if (cur.ctrl.out_b_action[1]) begin
                            nxt.wave_out_b = ~cur.ctrl.out_b_action[0];
                        end
                    end
                    if (m_a && !at_top) begin
                        nxt.wave_out_a = match_out(cur.ctrl.out_a_action, cur.wave_out_a, mode, 1'b0);
                    end
                    if (m_b && !(cur.ctrl.out_b_action[1] && at_top)) begin
                        nxt.wave_out_b = match_out(cur.ctrl.out_b_action, cur.wave_out_b, mode, 1'b0);
                    end
                end else begin
                    if (m_a) begin
                        nxt.wave_out_a = match_out(cur.ctrl.out_a_action, cur.wave_out_a, mode, 1'b0);
                    end
                    if (m_b) begin
                        nxt.wave_out_b = match_out(cur.ctrl.out_b_action, cur.wave_out_b, mode, 1'b0);
                    end
                end
            end
            nxt.flags.match_a = cur.flags.match_a | m_a;
            nxt.flags.match_b = cur.flags.match_b | m_b;
        end

        // APB access phase, one answer per transfer after one wait state
        nxt.pready = 1'b0;
        nxt.pslverr = 1'b0;
        if (apb_wr || apb_rd) begin
            nxt.pready = 1'b1;
        end
        case (I_PADDR)
            `ADDR_WAVE_CONTROL_A: begin
                rdat = {cur.ctrl.out_a_action, cur.ctrl.out_b_action, 2'b00, cur.ctrl.wave_mode_sel[1:0]};
                if (apb_wr) begin
                    nxt.ctrl.out_a_action = wdat[7:6];
                    nxt.ctrl.out_b_action = wdat[5:4];
                    nxt.ctrl.wave_mode_sel[1:0] = wdat[1:0];
                end
            end
            `ADDR_WAVE_CONTROL_B: begin
                rdat = {4'h0, cur.ctrl.wave_mode_sel[2], cur.ctrl.clock_prescale_sel};
                if (apb_wr) begin
                    nxt.ctrl.wave_mode_sel[2] = wdat[3];
                    nxt.ctrl.clock_prescale_sel = wdat[2:0];
                    // forced match changes output only, no flag, no clear
                    if (!is_pwm(mode) && wdat[7]) begin
                        nxt.wave_out_a = match_out(cur.ctrl.out_a_action, nxt.wave_out_a, mode, 1'b0);
                    end
                    if (!is_pwm(mode) && wdat[6]) begin
                        nxt.wave_out_b = match_out(cur.ctrl.out_b_action, nxt.wave_out_b, mode, 1'b0);
                    end
                end
            end
            `ADDR_COUNTER_VALUE: begin
                rdat = cur.counter_value;
                if (apb_wr) begin
                    nxt.counter_value = wdat;
                    nxt.block_match = 1'b1;
                end
            end
            `ADDR_COMPARE_VALUE_A: begin
                rdat = cur.cmp_buf.compare_value_a;
                if (apb_wr) begin
                    nxt.cmp_buf.compare_value_a = wdat;
                    if (!is_pwm(mode)) begin
                        nxt.cmp.compare_value_a = wdat;
                    end
                end
            end
            `ADDR_COMPARE_VALUE_B: begin
                rdat = cur.cmp_buf.compare_value_b;
                if (apb_wr) begin
                    nxt.cmp_buf.compare_value_b = wdat;
                    if (!is_pwm(mode)) begin
                        nxt.cmp.compare_value_b = wdat;
                    end
                end
            end
            `ADDR_EVENT_FLAGS: begin
                rdat = {5'h00, cur.flags.match_b, cur.flags.match_a, cur.flags.overflow};
                if (apb_wr) begin
                    // set wins over a same-cycle clear
                    // A flag that is already set and sets again in this cycle must survive the clear
                    nxt.flags.overflow = nxt.flags.overflow & ~(wdat[0] & ~ovf_ev);
                    nxt.flags.match_a = nxt.flags.match_a & ~(wdat[1] & ~m_a);
                    nxt.flags.match_b = nxt.flags.match_b & ~(wdat[2] & ~m_b);
                end
            end
            `ADDR_CLOCK_CONFIG: begin
                rdat = {7'h00, cur.async_clock_sel};
                if (apb_wr) begin
                    nxt.async_clock_sel = wdat[0];
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (apb_wr || apb_rd) begin
            nxt.pslverr = !hit;
            nxt.prdata = {24'h000000, rdat};
        end
        // Pin select is registered with the action field so it changes on the same edge
        nxt.ovr_a = |nxt.ctrl.out_a_action;
        nxt.ovr_b = |nxt.ctrl.out_b_action;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cur <= '0;
        end else if (I_CE) begin
            cur <= nxt;
        end
    end

    assign O_PREADY = cur.pready;
    assign O_PRDATA = cur.prdata;
    assign O_PSLVERR = cur.pslverr;
    assign O_WAVE_OUT_A = cur.wave_out_a;
    assign O_WAVE_OUT_B = cur.wave_out_b;
    assign O_PIN_OVERRIDE_A = cur.ovr_a;
    assign O_PIN_OVERRIDE_B = cur.ovr_b;
    assign O_MATCH_FLAG_A = cur.flags.match_a;
    assign O_MATCH_FLAG_B = cur.flags.match_b;
    assign O_OVERFLOW_FLAG = cur.flags.overflow;
endmodule
`default_nettype wire

/* File: rtl/timer8_map.svh */
`ifndef TIMER8_MAP_SVH
`define TIMER8_MAP_SVH
`define ADDR_WAVE_CONTROL_A 8'h00
`define ADDR_WAVE_CONTROL_B 8'h04
`define ADDR_COUNTER_VALUE 8'h08
`define ADDR_COMPARE_VALUE_A 8'h0C
`define ADDR_COMPARE_VALUE_B 8'h10
`define ADDR_EVENT_FLAGS 8'h14
`define ADDR_CLOCK_CONFIG 8'h18
`define CTRLA_RESET 8'h00
`define CTRLB_RESET 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
`define MODE_NORMAL 3'h0
`define MODE_PC_FF 3'h1
`define MODE_CTC 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PC_OCRA 3'h5
`define MODE_FAST_OCRA 3'h7
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3
`define PRESCALE_BITS 10
`endif

/* File: rtl/timer8_pkg.sv */
package timer8_pkg;
    typedef struct packed {
        logic [1:0] out_a_action;
        logic [1:0] out_b_action;
        logic [2:0] wave_mode_sel;
        logic [2:0] clock_prescale_sel;
    } ctrl_s;
    typedef struct packed {
        logic [7:0] compare_value_a;
        logic [7:0] compare_value_b;
    } cmp_s;
    typedef struct packed {
        logic match_a;
        logic match_b;
        logic overflow;
    } flags_s;
endpackage

/* File: rtl/timer8_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
`include "timer8_map.svh"
module timer8_prescaler (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Selection
    input wire logic [2:0] i_sel,
    output logic o_tick
);
    logic [`PRESCALE_BITS-1:0] div;
    logic [`PRESCALE_BITS-1:0] mask;
    always_comb begin
        case (i_sel)
            3'h2: mask = 10'h007;
            3'h3: mask = 10'h01F;
            3'h4: mask = 10'h03F;
            3'h5: mask = 10'h07F;
            3'h6: mask = 10'h0FF;
            3'h7: mask = 10'h3FF;
            default: mask = 10'h000;
        endcase
    end
    // Free running so a tick lands every divisor cycles of the source clock
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div <= 10'h000;
        end else if (i_ce) begin
            div <= div + 10'h001;
        end
    end
    assign o_tick = i_ce && (i_sel != 3'h0) && ((div & mask) == mask);
endmodule
`default_nettype wire

/* File: tb/timer8_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module timer8_pin_model (
    // From the block
    input wire logic i_wave,
    input wire logic i_override,
    // Port direction bit
    input wire logic i_dir_out,
    // Resolved pin level
    output logic o_pin
);
    // Pull-up keeps an undriven pin high, so a lost override never reads as a valid low
    assign o_pin = (i_override && i_dir_out) ? i_wave : 1'b1;
endmodule
`default_nettype wire

/* File: tb/timer8_waveform_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "timer8_map.svh"
module timer8_waveform_checker (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    // APB
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PSLVERR,
    // Pins and flags
    input wire logic O_PIN_OVERRIDE_A,
    input wire logic O_PIN_OVERRIDE_B,
    input wire logic O_MATCH_FLAG_B,
    input wire logic O_OVERFLOW_FLAG
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    wire wr = I_PSEL && I_PENABLE && I_PWRITE;
    wire clr = wr && (I_PADDR == `ADDR_EVENT_FLAGS);
    property p_ready_pulse; O_PREADY |=> !O_PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_err_ready; O_PSLVERR |-> O_PREADY; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_ready_cause; O_PREADY |-> $past(I_PSEL && I_PENABLE); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
    property p_upper_zero; O_PREADY |-> O_PRDATA[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
    property p_rdata_hold; !O_PREADY |-> $stable(O_PRDATA); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_ovr_a; $changed(O_PIN_OVERRIDE_A) |-> $past(wr); endproperty
    a_ovr_a: assert property (p_ovr_a) else $error("override a moved without write");
    property p_ovr_b; $changed(O_PIN_OVERRIDE_B) |-> $past(wr); endproperty
    a_ovr_b: assert property (p_ovr_b) else $error("override b moved without write");
    property p_flag_b_clr; $fell(O_MATCH_FLAG_B) |-> $past(clr && I_PWDATA[2]); endproperty
    a_flag_b_clr: assert property (p_flag_b_clr) else $error("match flag b fell alone");
    property p_ovf_clr; $fell(O_OVERFLOW_FLAG) |-> $past(clr && I_PWDATA[0]); endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag fell alone");
endmodule
bind timer8_waveform_control timer8_waveform_checker timer8_waveform_checker_i (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
    .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .O_PIN_OVERRIDE_A(O_PIN_OVERRIDE_A),
    .O_PIN_OVERRIDE_B(O_PIN_OVERRIDE_B), .O_MATCH_FLAG_B(O_MATCH_FLAG_B), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG)
);
`default_nettype wire

/* File: tb/timer8_waveform_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "timer8_map.svh"
module timer8_waveform_control_bench;
    logic clk, rst_b, ce, psel, penable, pwrite, lf_tick, dir_b, pin_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, wave_a, wave_b, ovr_a, ovr_b, flag_a, flag_b, flag_o;
    int fails, checks;
    typedef struct packed { logic [7:0] a; logic [31:0] d; logic [7:0] q; } reg_row_s;
    typedef struct packed {
        logic [2:0] m;
        logic [1:0] act;
        logic [7:0] ta;
        logic [7:0] tb;
        logic [10:0] hi;
    } pwm_row_s;
    localparam reg_row_s REGS [8] = '{'{`ADDR_WAVE_CONTROL_B, 32'h0, 8'h0}, '{`ADDR_WAVE_CONTROL_A, 32'hFF, 8'hF3},
        '{`ADDR_WAVE_CONTROL_A, 32'h0C, 8'h0}, '{`ADDR_WAVE_CONTROL_B, 32'h3F, 8'h0F},
        '{`ADDR_WAVE_CONTROL_B, 32'hF0, 8'h0}, '{`ADDR_COUNTER_VALUE, 32'h5A, 8'h5A},
        '{`ADDR_COMPARE_VALUE_A, 32'h123, 8'h23}, '{`ADDR_COMPARE_VALUE_B, 32'h5C, 8'h5C}};
    localparam pwm_row_s PWMS [5] = '{'{3'h3, 2'h2, 8'h0, 8'h40, 11'd255}, '{3'h3, 2'h3, 8'h0, 8'h40, 11'd765},
        '{3'h1, 2'h2, 8'h0, 8'h40, 11'd256}, '{3'h1, 2'h3, 8'h0, 8'h40, 11'd764},
        '{3'h7, 2'h2, 8'h40, 8'h40, 11'd1020}};
    localparam logic [1:0] FACT [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    localparam logic FEXP [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    localparam int DIVS [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    timer8_waveform_control timer8_waveform_control_i (
        .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_LF_TICK(lf_tick),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
        .O_WAVE_OUT_A(wave_a), .O_WAVE_OUT_B(wave_b), .O_PIN_OVERRIDE_A(ovr_a), .O_PIN_OVERRIDE_B(ovr_b),
        .O_MATCH_FLAG_A(flag_a), .O_MATCH_FLAG_B(flag_b), .O_OVERFLOW_FLAG(flag_o)
    );
    timer8_pin_model timer8_pin_model_i (.i_wave(wave_b), .i_override(ovr_b), .i_dir_out(dir_b), .o_pin(pin_b));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    // Master holds the request until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No answer time is assumed; only the watchdog ends a wait that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        final_report();
    end
    initial begin
        logic [31:0] r;
        logic e;
        int hi;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        lf_tick = 1'b0;
        ce = 1'b1;
        dir_b = 1'b1;
        rst_b = 1'b0;
        do_reset();
        for (int a = 0; a < 28; a += 4) begin
            rd(8'(a), r);
            chk("reset value", 32'h0, r);
        end
        apb(1'b0, 8'h1C, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        done("reset");
        foreach (REGS[i]) begin
            wr(REGS[i].a, REGS[i].d);
            rd(REGS[i].a, r);
            chk("register readback", {24'h0, REGS[i].q}, r);
        end
        done("registers");
        for (int k = 0; k < 4; k++) begin
            wr(`ADDR_WAVE_CONTROL_A, {24'h0, FACT[k], FACT[k], 4'h0});
            wr(`ADDR_WAVE_CONTROL_B, 32'hC0);
            chk("forced level", {31'h0, FEXP[k]}, {31'h0, wave_b});
            chk("forced level a", {31'h0, FEXP[k]}, {31'h0, wave_a});
            chk("pin follows wave", {31'h0, wave_b}, {31'h0, pin_b});
        end
        chk("override b", 32'h1, {31'h0, ovr_b});
        chk("override a", 32'h1, {31'h0, ovr_a});
        rd(`ADDR_EVENT_FLAGS, r);
        chk("flags after force", 32'h0, r);
        dir_b <= 1'b0;
        @(negedge clk);
        chk("pin released", 32'h1, {31'h0, pin_b});
        dir_b <= 1'b1;
        done("force");
        wr(`ADDR_WAVE_CONTROL_A, 32'h0);
        wr(`ADDR_COMPARE_VALUE_A, 32'h0);
        wr(`ADDR_COMPARE_VALUE_B, 32'h10);
        wr(`ADDR_COUNTER_VALUE, 32'hFD);
        wr(`ADDR_WAVE_CONTROL_B, 32'h1);
        repeat (40) @(posedge clk);
        wr(`ADDR_WAVE_CONTROL_B, 32'h0);
        chk("overflow pin", 32'h1, {31'h0, flag_o});
        chk("match flag a pin", 32'h1, {31'h0, flag_a});
        rd(`ADDR_COUNTER_VALUE, r);
        chk("wrapped count", 32'h1, {31'h0, r >= 32'h28 && r <= 32'h2A});
        rd(`ADDR_EVENT_FLAGS, r);
        chk("flags set", 32'h7, r);
        wr(`ADDR_EVENT_FLAGS, 32'h7);
        rd(`ADDR_EVENT_FLAGS, r);
        chk("flags cleared", 32'h0, r);
        done("normal");
        wr(`ADDR_COMPARE_VALUE_A, 32'h5);
        wr(`ADDR_COUNTER_VALUE, 32'h0);
        wr(`ADDR_WAVE_CONTROL_A, 32'h2);
        wr(`ADDR_WAVE_CONTROL_B, 32'h1);
        repeat (40) @(posedge clk);
        wr(`ADDR_WAVE_CONTROL_B, 32'h0);
        rd(`ADDR_COUNTER_VALUE, r);
        chk("clear on match top", 32'h1, {31'h0, r <= 32'h5});
        chk("no overflow below max", 32'h0, {31'h0, flag_o});
        done("clear on match");
        wr(`ADDR_WAVE_CONTROL_A, 32'h0);
        wr(`ADDR_COUNTER_VALUE, 32'h0);
        wr(`ADDR_CLOCK_CONFIG, 32'h1);
        wr(`ADDR_WAVE_CONTROL_B, 32'h1);
        repeat (20) @(posedge clk);
        repeat (5) begin
            lf_tick <= 1'b1;
            @(posedge clk);
            lf_tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
        wr(`ADDR_WAVE_CONTROL_B, 32'h0);
        wr(`ADDR_CLOCK_CONFIG, 32'h0);
        rd(`ADDR_COUNTER_VALUE, r);
        chk("low frequency ticks", 32'h5, r);
        done("source select");
        // Window between the two control writes is exactly twenty prescaled periods
        for (int s = 1; s < 8; s++) begin
            wr(`ADDR_COUNTER_VALUE, 32'h0);
            wr(`ADDR_WAVE_CONTROL_B, 32'(s));
            repeat (DIVS[s] * 20 - 4) @(posedge clk);
            wr(`ADDR_WAVE_CONTROL_B, 32'h0);
            rd(`ADDR_COUNTER_VALUE, r);
            chk("prescaled count", 32'h1, {31'h0, r >= 32'd19 && r <= 32'd21});
        end
        done("prescaler");
        // One tick before the freeze and three while the stop write is carried
        wr(`ADDR_COUNTER_VALUE, 32'h0);
        wr(`ADDR_WAVE_CONTROL_B, 32'h1);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wr(`ADDR_WAVE_CONTROL_B, 32'h0);
        rd(`ADDR_COUNTER_VALUE, r);
        chk("frozen while disabled", 32'h4, r);
        done("clock enable");
        foreach (PWMS[i]) begin
            wr(`ADDR_WAVE_CONTROL_B, 32'h0);
            wr(`ADDR_COMPARE_VALUE_A, {24'h0, PWMS[i].ta});
            wr(`ADDR_COMPARE_VALUE_B, {24'h0, PWMS[i].tb});
            wr(`ADDR_WAVE_CONTROL_A, {26'h0, PWMS[i].act, 2'h0, PWMS[i].m[1:0]});
            wr(`ADDR_COUNTER_VALUE, 32'h0);
            wr(`ADDR_WAVE_CONTROL_B, {28'h0, PWMS[i].m[2], 3'h1});
            repeat (600) @(posedge clk);
            hi = 0;
            repeat (1020) begin
                @(negedge clk);
                if (wave_b === 1'b1) hi++;
            end
            hi -= int'(PWMS[i].hi);
            chk("pwm high time", 32'h1, {31'h0, hi >= -12 && hi <= 12});
            chk("pwm pin", {31'h0, wave_b}, {31'h0, pin_b});
        end
        done("pwm");
        do_reset();
        rd(`ADDR_WAVE_CONTROL_A, r);
        chk("control after reset", 32'h0, r);
        chk("override after reset", 32'h0, {30'h0, ovr_a, ovr_b});
        done("second reset");
        final_report();
    end
endmodule
`default_nettype wire
